// file: rtl/mrs_pkg.sv
package mrs_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W   = 32;
  localparam int SUM_W    = 48;
  localparam int CNT_W    = 16;
  localparam int CH_W     = 5;
  localparam int LP_CH    = 32;
  localparam int LP_GROUP = 16;
  localparam int MIN_W    = 6;
  localparam int IDX_W    = 4;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_INTERVAL   = 8'h04;
  localparam logic [7:0] OFF_BPR_CFG    = 8'h08;
  localparam logic [7:0] OFF_SCALE      = 8'h0C;
  localparam logic [7:0] OFF_COMP_SEL   = 8'h10;
  localparam logic [7:0] OFF_KIND       = 8'h14;
  localparam logic [7:0] OFF_SEASON_SEL = 8'h18;
  localparam logic [7:0] OFF_WORKING    = 8'h20;
  localparam logic [7:0] OFF_BILLING    = 8'h24;
  localparam logic [7:0] OFF_SEASON     = 8'h28;
  localparam logic [7:0] OFF_CUMUL      = 8'h2C;
  localparam logic [7:0] OFF_CONT_CUMUL = 8'h30;
  localparam logic [7:0] OFF_PREV_HOUR  = 8'h34;
  localparam logic [7:0] OFF_PREV_DAY   = 8'h38;
  localparam logic [7:0] OFF_PEAK       = 8'h3C;
  localparam logic [7:0] OFF_PEAK_TIME  = 8'h40;
  localparam logic [7:0] OFF_COINC      = 8'h44;
  localparam logic [7:0] OFF_BILL_PEAK  = 8'h48;
  localparam logic [7:0] OFF_STATUS     = 8'h4C;

  // ==========================================================
  // fields and reset values
  localparam int CTRL_FMT_BIT    = 0;
  localparam int CTRL_GROUP2_BIT = 1;
  localparam int INTERVAL_CNT    = 12;
  localparam logic [IDX_W-1:0]  INTERVAL_RST = 4'h8;
  localparam logic [CNT_W-1:0]  SCALE_RST    = 16'h0001;
  localparam logic [DATA_W-1:0] ZERO32       = 32'h0000_0000;
  localparam logic [SUM_W-1:0]  ZERO48       = 48'h0000_0000_0000;
  localparam logic [CNT_W-1:0]  ZERO16       = 16'h0000;
  localparam logic [CNT_W-1:0]  ONE16        = 16'h0001;

  // recording intervals in minutes, indexed by the interval register
  localparam logic [MIN_W-1:0] INTERVAL_MIN [INTERVAL_CNT] =
    '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
      6'h0A, 6'h0C, 6'h0F, 6'h14, 6'h1E, 6'h3C};

  // ==========================================================
  // load-profile number formats
  localparam logic [SUM_W-1:0]  ENG_CEILING = 48'h0001_0000_0000;
  localparam logic [CNT_W-1:0]  CNT_CEILING = 16'h3FFF;
  localparam int                CNT_SHIFT   = 16;
  localparam logic [7:0]        FLT_BIAS    = 8'h7F;
  localparam int                DIV_STEPS   = 48;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic              valid;
    logic [CH_W-1:0]   chan;
    logic [DATA_W-1:0] comp;
    logic [DATA_W-1:0] uncomp;
  } mrs_sample_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] value;
    logic [DATA_W-1:0] coincident;
  } mrs_demand_t;

  typedef struct packed {
    logic              valid;
    logic [CH_W-1:0]   chan;
    logic [DATA_W-1:0] data;
  } mrs_record_t;

endpackage : mrs_pkg

// file: rtl/mrs_storage.sv
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module mrs_storage (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  energy_valid,
  input  wire logic [15:0]           energy_inc,
  input  wire mrs_pkg::mrs_demand_t  demand,
  input  wire logic [31:0]           time_now,
  input  wire logic                  billing_period_reset,
  input  wire logic                  season_change,
  input  wire logic                  minute_tick,
  input  wire logic                  hour_tick,
  input  wire logic                  day_tick,
  input  wire mrs_pkg::mrs_sample_t  sample,
  output var  mrs_pkg::mrs_record_t  record
);

  // ==========================================================
  // state types
  typedef enum logic [3:0] {
    LP_IDLE  = 4'b0001,
    LP_FETCH = 4'b0010,
    LP_DIV   = 4'b0100,
    LP_EMIT  = 4'b1000
  } mrs_lp_state_t;

  // ==========================================================
  // configuration registers
  logic [1:0]                   ctrl_reg;
  logic [mrs_pkg::IDX_W-1:0]    interval_reg;
  logic [31:0]                  bpr_cfg_reg;
  logic [mrs_pkg::CNT_W-1:0]    scale_reg;
  logic [31:0]                  comp_sel_reg;
  logic [31:0]                  kind_reg;
  logic                         season_sel_reg;

  // storage registers
  logic [31:0]                  working_reg;
  logic [31:0]                  billing_reg;
  logic [31:0]                  season_reg;
  logic [31:0]                  cumul_reg;
  logic [31:0]                  cont_cumul_reg;
  logic [31:0]                  hour_acc_reg;
  logic [31:0]                  prev_hour_reg;
  logic [31:0]                  day_acc_reg;
  logic [31:0]                  prev_day_reg;
  logic [31:0]                  peak_reg;
  logic [31:0]                  peak_time_reg;
  logic [31:0]                  coinc_reg;
  logic [31:0]                  bill_peak_reg;

  logic                         wr_en;
  logic                         rd_setup;
  logic                         bad_interval;
  logic                         cfg_change;
  logic [31:0]                  inc32;
  logic [31:0]                  working_next;
  logic                         new_peak;

  // ==========================================================
  // apb slave: read data is staged at the setup edge, so a
  // transfer finishes in its first access cycle whenever clk_en is high
  assign pready       = clk_en;
  assign wr_en        = clk_en & psel & penable & pwrite;
  assign rd_setup     = clk_en & psel & ~penable & ~pwrite;
  assign bad_interval = (paddr == mrs_pkg::OFF_INTERVAL) &&
                        (pwdata[mrs_pkg::IDX_W-1:0] >= 4'(mrs_pkg::INTERVAL_CNT));
  assign pslverr      = psel & penable & pwrite & bad_interval & clk_en;
  assign cfg_change   = wr_en && (paddr == mrs_pkg::OFF_BPR_CFG) && (pwdata != bpr_cfg_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg       <= 2'h0;
      interval_reg   <= mrs_pkg::INTERVAL_RST;
      bpr_cfg_reg    <= mrs_pkg::ZERO32;
      scale_reg      <= mrs_pkg::SCALE_RST;
      comp_sel_reg   <= mrs_pkg::ZERO32;
      kind_reg       <= mrs_pkg::ZERO32;
      season_sel_reg <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        mrs_pkg::OFF_CTRL:       ctrl_reg       <= pwdata[1:0];
        mrs_pkg::OFF_INTERVAL: begin
          // out-of-set codes are refused so the interval stays legal
          if (!bad_interval) begin
            interval_reg <= pwdata[mrs_pkg::IDX_W-1:0];
          end
        end
        mrs_pkg::OFF_BPR_CFG:    bpr_cfg_reg    <= pwdata;
        mrs_pkg::OFF_SCALE:      scale_reg      <= pwdata[mrs_pkg::CNT_W-1:0];
        mrs_pkg::OFF_COMP_SEL:   comp_sel_reg   <= pwdata;
        mrs_pkg::OFF_KIND:       kind_reg       <= pwdata;
        mrs_pkg::OFF_SEASON_SEL: season_sel_reg <= pwdata[0];
        default: ;
      endcase
    end
  end

  logic        lp_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= mrs_pkg::ZERO32;
    end else if (rd_setup) begin
      case (paddr)
        mrs_pkg::OFF_CTRL:       prdata <= {30'h0000_0000, ctrl_reg};
        mrs_pkg::OFF_INTERVAL:   prdata <= {28'h000_0000, interval_reg};
        mrs_pkg::OFF_BPR_CFG:    prdata <= bpr_cfg_reg;
        mrs_pkg::OFF_SCALE:      prdata <= {16'h0000, scale_reg};
        mrs_pkg::OFF_COMP_SEL:   prdata <= comp_sel_reg;
        mrs_pkg::OFF_KIND:       prdata <= kind_reg;
        mrs_pkg::OFF_SEASON_SEL: prdata <= {31'h0000_0000, season_sel_reg};
        mrs_pkg::OFF_WORKING:    prdata <= working_reg;
        mrs_pkg::OFF_BILLING:    prdata <= billing_reg;
        mrs_pkg::OFF_SEASON:     prdata <= season_reg;
        mrs_pkg::OFF_CUMUL:      prdata <= cumul_reg;
        mrs_pkg::OFF_CONT_CUMUL: prdata <= cont_cumul_reg;
        mrs_pkg::OFF_PREV_HOUR:  prdata <= prev_hour_reg;
        mrs_pkg::OFF_PREV_DAY:   prdata <= prev_day_reg;
        mrs_pkg::OFF_PEAK:       prdata <= peak_reg;
        mrs_pkg::OFF_PEAK_TIME:  prdata <= peak_time_reg;
        mrs_pkg::OFF_COINC:      prdata <= coinc_reg;
        mrs_pkg::OFF_BILL_PEAK:  prdata <= bill_peak_reg;
        mrs_pkg::OFF_STATUS:     prdata <= {31'h0000_0000, lp_busy};
        default:                 prdata <= mrs_pkg::ZERO32;
      endcase
    end
  end

  // ==========================================================
  // energy storage registers
  assign inc32        = energy_valid ? {16'h0000, energy_inc} : mrs_pkg::ZERO32;
  assign working_next = working_reg + inc32;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_reg <= mrs_pkg::ZERO32;
    end else if (clk_en) begin
      // never cleared by a billing reset
      working_reg <= working_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      billing_reg   <= mrs_pkg::ZERO32;
      bill_peak_reg <= mrs_pkg::ZERO32;
    end else if (clk_en && billing_period_reset) begin
      billing_reg   <= working_reg;
      bill_peak_reg <= peak_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      season_reg <= mrs_pkg::ZERO32;
    end else if (clk_en && season_change) begin
      season_reg <= season_sel_reg ? peak_reg : working_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cumul_reg      <= mrs_pkg::ZERO32;
      cont_cumul_reg <= mrs_pkg::ZERO32;
    end else if (clk_en) begin
      if (cfg_change) begin
        // a config change wins over a same-cycle billing reset
        cumul_reg      <= mrs_pkg::ZERO32;
        cont_cumul_reg <= mrs_pkg::ZERO32;
      end else begin
        if (billing_period_reset) begin
          cumul_reg <= cumul_reg + working_reg;
        end
        cont_cumul_reg <= cumul_reg + working_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hour_acc_reg  <= mrs_pkg::ZERO32;
      prev_hour_reg <= mrs_pkg::ZERO32;
    end else if (clk_en) begin
      if (hour_tick) begin
        // the increment of the boundary cycle belongs to the ending hour
        prev_hour_reg <= hour_acc_reg + inc32;
        hour_acc_reg  <= mrs_pkg::ZERO32;
      end else begin
        hour_acc_reg  <= hour_acc_reg + inc32;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      day_acc_reg  <= mrs_pkg::ZERO32;
      prev_day_reg <= mrs_pkg::ZERO32;
    end else if (clk_en) begin
      if (day_tick) begin
        prev_day_reg <= day_acc_reg + inc32;
        day_acc_reg  <= mrs_pkg::ZERO32;
      end else begin
        day_acc_reg  <= day_acc_reg + inc32;
      end
    end
  end

  // ==========================================================
  // peak demand with time and coincident value
  assign new_peak = demand.valid && (demand.value > peak_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_reg      <= mrs_pkg::ZERO32;
      peak_time_reg <= mrs_pkg::ZERO32;
      coinc_reg     <= mrs_pkg::ZERO32;
    end else if (clk_en) begin
      if (billing_period_reset) begin
        peak_reg <= mrs_pkg::ZERO32;
      end else if (new_peak) begin
        peak_reg      <= demand.value;
        peak_time_reg <= time_now;
        coinc_reg     <= demand.coincident;
      end
    end
  end

  // ==========================================================
  // load profile accumulators, one per channel
  logic [mrs_pkg::SUM_W-1:0] sum_mem [mrs_pkg::LP_CH];
  logic [mrs_pkg::CNT_W-1:0] cnt_mem [mrs_pkg::LP_CH];
  mrs_lp_state_t             lp_state_reg;
  logic [mrs_pkg::CH_W-1:0]  ch_reg;
  logic [mrs_pkg::SUM_W-1:0] dvd_reg;
  logic [mrs_pkg::CNT_W:0]   rem_reg;
  logic [mrs_pkg::CNT_W-1:0] dvs_reg;
  logic [5:0]                step_reg;
  logic [mrs_pkg::MIN_W-1:0] min_cnt_reg;
  logic                      interval_end;
  logic                      group2;
  logic [mrs_pkg::CH_W-1:0]  last_ch;
  logic [mrs_pkg::DATA_W-1:0] sample_val;
  logic [mrs_pkg::CNT_W:0]   rem_shift;

  assign group2     = ctrl_reg[mrs_pkg::CTRL_GROUP2_BIT];
  assign last_ch    = group2 ? 5'h1F : 5'h0F;
  assign sample_val = comp_sel_reg[sample.chan] ? sample.comp : sample.uncomp;
  assign lp_busy    = (lp_state_reg != LP_IDLE);

  genvar gi;
  generate
    for (gi = 0; gi < mrs_pkg::LP_CH; gi++) begin : g_acc
      logic add_hit;
      logic clr_hit;
      // second-group channels only collect while that group is enabled
      assign add_hit = sample.valid && (sample.chan == 5'(gi)) &&
                       ((gi < mrs_pkg::LP_GROUP) || group2);
      assign clr_hit = (lp_state_reg == LP_FETCH) && (ch_reg == 5'(gi));

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sum_mem[gi] <= mrs_pkg::ZERO48;
          cnt_mem[gi] <= mrs_pkg::ZERO16;
        end else if (clk_en) begin
          if (clr_hit) begin
            // a sample in the fetch cycle opens the next interval
            sum_mem[gi] <= add_hit ? {16'h0000, sample_val} : mrs_pkg::ZERO48;
            cnt_mem[gi] <= add_hit ? mrs_pkg::ONE16 : mrs_pkg::ZERO16;
          end else if (add_hit) begin
            sum_mem[gi] <= sum_mem[gi] + {16'h0000, sample_val};
            cnt_mem[gi] <= cnt_mem[gi] + mrs_pkg::ONE16;
          end
        end
      end
    end
  endgenerate

  // interval timer on minute ticks
  assign interval_end = minute_tick &&
                        (min_cnt_reg + 6'h01 >= mrs_pkg::INTERVAL_MIN[interval_reg]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_cnt_reg <= 6'h00;
    end else if (clk_en && minute_tick) begin
      min_cnt_reg <= interval_end ? 6'h00 : min_cnt_reg + 6'h01;
    end
  end

  // ==========================================================
  // record formatting
  function automatic logic [31:0] mrs_to_float(input logic [47:0] v);
    logic [47:0] n;
    logic [5:0]  p;
    p = 6'h00;
    n = v;
    for (int i = 0; i < 48; i++) begin
      if (v[i]) begin
        p = 6'(i);
      end
    end
    n = v << (6'd47 - p);
    if (v == mrs_pkg::ZERO48) begin
      mrs_to_float = mrs_pkg::ZERO32;
    end else begin
      mrs_to_float = {1'b0, mrs_pkg::FLT_BIAS + {2'b00, p}, n[46:24]};
    end
  endfunction : mrs_to_float

  logic [mrs_pkg::SUM_W-1:0] eng_val;
  logic [63:0]               scaled;
  logic [47:0]               cnt_raw;
  logic [31:0]               fmt_data;

  always_comb begin
    eng_val = (dvd_reg > mrs_pkg::ENG_CEILING) ? mrs_pkg::ENG_CEILING : dvd_reg;
    scaled  = {16'h0000, dvd_reg} * {48'h0000_0000_0000, scale_reg};
    cnt_raw = scaled[63:mrs_pkg::CNT_SHIFT];
    if (ctrl_reg[mrs_pkg::CTRL_FMT_BIT]) begin
      // saturate instead of wrapping so an overload still reads high
      fmt_data = (cnt_raw > {32'h0000_0000, mrs_pkg::CNT_CEILING}) ?
                 {16'h0000, mrs_pkg::CNT_CEILING} : {16'h0000, cnt_raw[15:0]};
    end else begin
      fmt_data = mrs_to_float(eng_val);
    end
  end

  // ==========================================================
  // interval dump: one channel at a time, averages by a serial divide unless the channel's kind bit is set
  assign rem_shift = {rem_reg[mrs_pkg::CNT_W-1:0], dvd_reg[mrs_pkg::SUM_W-1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_state_reg <= LP_IDLE;
      ch_reg       <= 5'h00;
      dvd_reg      <= mrs_pkg::ZERO48;
      rem_reg      <= 17'h0_0000;
      dvs_reg      <= mrs_pkg::ZERO16;
      step_reg     <= 6'h00;
      record       <= '0;
    end else if (clk_en) begin
      record.valid <= 1'b0;
      case (lp_state_reg)
        LP_IDLE: begin
          // a dump lasts far under a minute, so ends never overlap
          if (interval_end) begin
            ch_reg       <= 5'h00;
            lp_state_reg <= LP_FETCH;
          end
        end
        LP_FETCH: begin
          dvd_reg  <= sum_mem[ch_reg];
          dvs_reg  <= cnt_mem[ch_reg];
          rem_reg  <= 17'h0_0000;
          step_reg <= 6'h00;
          if (kind_reg[ch_reg] || (cnt_mem[ch_reg] == mrs_pkg::ZERO16)) begin
            lp_state_reg <= LP_EMIT;
          end else begin
            lp_state_reg <= LP_DIV;
          end
        end
        LP_DIV: begin
          if (rem_shift >= {1'b0, dvs_reg}) begin
            rem_reg <= rem_shift - {1'b0, dvs_reg};
            dvd_reg <= {dvd_reg[mrs_pkg::SUM_W-2:0], 1'b1};
          end else begin
            rem_reg <= rem_shift;
            dvd_reg <= {dvd_reg[mrs_pkg::SUM_W-2:0], 1'b0};
          end
          step_reg <= step_reg + 6'h01;
          if (step_reg == 6'(mrs_pkg::DIV_STEPS - 1)) begin
            lp_state_reg <= LP_EMIT;
          end
        end
        LP_EMIT: begin
          record.valid <= 1'b1;
          record.chan  <= ch_reg;
          record.data  <= fmt_data;
          ch_reg       <= ch_reg + 5'h01;
          lp_state_reg <= (ch_reg == last_ch) ? LP_IDLE : LP_FETCH;
        end
        default: lp_state_reg <= LP_IDLE;
      endcase
    end
  end

endmodule : mrs_storage

`default_nettype wire

// file: tb/mrs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_assertions (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 clk_en,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 billing_period_reset,
  input wire mrs_pkg::mrs_demand_t demand,
  input wire mrs_pkg::mrs_record_t record
);
  // ==========
  // control bits tracked from the bus itself, last channel from the record output
  logic       fmt_reg;
  logic       grp_reg;
  logic [4:0] chan_reg;
  wire logic  ctrl_wr = psel && penable && pwrite && pready && paddr == mrs_pkg::OFF_CTRL;
  wire logic  ivl_wr = psel && penable && pwrite && clk_en && paddr == mrs_pkg::OFF_INTERVAL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_reg <= 1'b0;
      grp_reg <= 1'b0;
    end else if (ctrl_wr) begin
      fmt_reg <= pwdata[0];
      grp_reg <= pwdata[1];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_reg <= 5'h00;
    end else if (record.valid) begin
      chan_reg <= record.chan;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence bpr_s;
    billing_period_reset && clk_en;
  endsequence
  sequence peak_rd_s;
    psel && !penable && !pwrite && clk_en && paddr == mrs_pkg::OFF_PEAK;
  endsequence
  chk_pready_follow: assert property (pready == clk_en)
    else $error("pready does not follow clock enable");
  chk_bad_interval: assert property (ivl_wr && pwdata[3:0] >= 4'hC |-> pslverr)
    else $error("bad interval code not refused");
  chk_err_cause: assert property (pslverr |-> ivl_wr && pwdata[3:0] >= 4'hC)
    else $error("error flag without a bad interval write");
  // a fresh peak in the gap may legally refill the register, so it is excluded
  chk_peak_clear: assert property (
    bpr_s ##1 !demand.valid ##1 peak_rd_s |=> prdata == 32'h0000_0000)
    else $error("peak not cleared by billing reset");
  chk_rec_pulse: assert property (record.valid |=> !record.valid)
    else $error("record valid longer than one cycle");
  chk_count_cap: assert property (record.valid && fmt_reg |-> record.data <= 32'h0000_3FFF)
    else $error("count record above ceiling");
  chk_group_limit: assert property (record.valid && !grp_reg |-> record.chan < 5'h10)
    else $error("second group channel without enable");
  chk_chan_order: assert property (
    record.valid |-> record.chan == 5'h00 || record.chan == 5'(chan_reg + 5'h01))
    else $error("channels dumped out of order");
endmodule : mrs_assertions
bind mrs_storage mrs_assertions u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .billing_period_reset, .demand, .record);
`default_nettype wire

// file: tb/mrs_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module mrs_front_end (
  input wire logic             pclk,
  output logic                 energy_valid,
  output logic [15:0]          energy_inc,
  output mrs_pkg::mrs_demand_t demand,
  output logic [31:0]          time_now,
  output mrs_pkg::mrs_sample_t sample
);
  // ==========
  // idle fields are inverted, except time_now, which keeps showing the last value
  initial begin
    energy_valid = 1'b0;
    energy_inc = 16'h0000;
    demand = '0;
    time_now = 32'h0000_0000;
    sample = '0;
  end
  task automatic feed(input int n, input logic [15:0] inc);
    @(posedge pclk);
    energy_valid <= 1'b1;
    energy_inc <= inc;
    repeat (n) @(posedge pclk);
    energy_valid <= 1'b0;
    energy_inc <= ~inc;
  endtask : feed
  task automatic peak(input logic [31:0] v, input logic [31:0] c, input logic [31:0] t);
    @(posedge pclk);
    demand <= '{1'b1, v, c};
    time_now <= t;
    @(posedge pclk);
    demand <= '{1'b0, ~v, ~c};
  endtask : peak
  task automatic send(input logic [4:0] ch, input logic [31:0] c, input logic [31:0] u);
    @(posedge pclk);
    sample <= '{1'b1, ch, c, u};
    @(posedge pclk);
    sample <= '{1'b0, ~ch, ~c, ~u};
  endtask : send
endmodule : mrs_front_end
`default_nettype wire

// file: tb/meter_register_storage_test.sv
`timescale 1ns/1ps
`default_nettype none
module meter_register_storage_test;
  // ==========
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [4:0] tick = 5'h00;
  logic [31:0] prdata, rdv, tnow;
  logic [31:0] recs [32];
  logic pready, pslverr, ev, err;
  logic [15:0] einc;
  mrs_pkg::mrs_demand_t dem;
  mrs_pkg::mrs_sample_t smp;
  mrs_pkg::mrs_record_t rec;
  int bad_count = 0;
  int n_tests = 0;
  always #2.5 pclk = ~pclk;
  mrs_storage u_mrs_storage (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .energy_valid(ev), .energy_inc(einc),
    .demand(dem), .time_now(tnow), .billing_period_reset(tick[4]), .season_change(tick[3]),
    .minute_tick(tick[2]), .hour_tick(tick[1]), .day_tick(tick[0]), .sample(smp),
    .record(rec));
  mrs_front_end u_mrs_front_end (.pclk, .energy_valid(ev), .energy_inc(einc), .demand(dem),
    .time_now(tnow), .sample(smp));
  always @(posedge pclk) begin
    if (rec.valid === 1'b1) begin
      recs[rec.chan] = rec.data;
    end
  end
  // ==========
  // bus and check helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) bad_count++;
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, e);
  endtask : rd
  task automatic pulse(input logic [4:0] m);
    @(posedge pclk);
    tick <= m;
    @(posedge pclk);
    tick <= 5'h00;
  endtask : pulse
  // a dump may run up to 32 channels of 50 cycles, so poll busy rather than guess
  task automatic dump;
    int n;
    n = 0;
    pulse(5'h04);
    do begin
      apb(1'b0, mrs_pkg::OFF_STATUS, 32'h0000_0000);
      n++;
    end while (rdv[0] !== 1'b0 && n < 700);
    if (rdv[0] !== 1'b0) bad_count++;
  endtask : dump
  // ==========
  // scenarios
  task automatic t_regs;
    rd(mrs_pkg::OFF_INTERVAL, 32'h0000_0008);
    rd(mrs_pkg::OFF_SCALE, 32'h0000_0001);
    apb(1'b1, mrs_pkg::OFF_INTERVAL, 32'h0000_000C);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    rd(mrs_pkg::OFF_INTERVAL, 32'h0000_0008);
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, mrs_pkg::OFF_INTERVAL, 32'(i));
      rd(mrs_pkg::OFF_INTERVAL, 32'(i));
    end
    rd(8'hFC, 32'h0000_0000);
    $display("registers done");
  endtask : t_regs
  task automatic t_store;
    u_mrs_front_end.feed(20, 16'h0003);
    rd(mrs_pkg::OFF_WORKING, 32'h0000_003C);
    u_mrs_front_end.peak(32'h0000_01F4, 32'h0000_004D, 32'h0000_04D2);
    u_mrs_front_end.peak(32'h0000_0190, 32'h0000_0058, 32'h0000_0063);
    rd(mrs_pkg::OFF_PEAK_TIME, 32'h0000_04D2);
    rd(mrs_pkg::OFF_COINC, 32'h0000_004D);
    rd(mrs_pkg::OFF_BILLING, 32'h0000_0000);
    pulse(5'h10);
    rd(mrs_pkg::OFF_PEAK, 32'h0000_0000);
    rd(mrs_pkg::OFF_BILL_PEAK, 32'h0000_01F4);
    rd(mrs_pkg::OFF_WORKING, 32'h0000_003C);
    rd(mrs_pkg::OFF_CUMUL, 32'h0000_003C);
    u_mrs_front_end.feed(10, 16'h0002);
    rd(mrs_pkg::OFF_BILLING, 32'h0000_003C);
    rd(mrs_pkg::OFF_CONT_CUMUL, 32'h0000_008C);
    pulse(5'h18);
    rd(mrs_pkg::OFF_CUMUL, 32'h0000_008C);
    u_mrs_front_end.feed(5, 16'h0001);
    rd(mrs_pkg::OFF_SEASON, 32'h0000_0050);
    apb(1'b1, mrs_pkg::OFF_BPR_CFG, 32'h0000_0001);
    rd(mrs_pkg::OFF_CUMUL, 32'h0000_0000);
    rd(mrs_pkg::OFF_CONT_CUMUL, 32'h0000_0055);
    apb(1'b1, mrs_pkg::OFF_SEASON_SEL, 32'h0000_0001);
    u_mrs_front_end.peak(32'h0000_0123, 32'h0000_0001, 32'h0000_0002);
    pulse(5'h08);
    rd(mrs_pkg::OFF_SEASON, 32'h0000_0123);
    $display("storage done");
  endtask : t_store
  task automatic t_hd;
    pulse(5'h03);
    u_mrs_front_end.feed(7, 16'h0004);
    pulse(5'h03);
    u_mrs_front_end.feed(3, 16'h0001);
    pulse(5'h02);
    rd(mrs_pkg::OFF_PREV_HOUR, 32'h0000_0003);
    rd(mrs_pkg::OFF_PREV_DAY, 32'h0000_001C);
    $display("hour and day done");
  endtask : t_hd
  task automatic t_lp;
    apb(1'b1, mrs_pkg::OFF_KIND, 32'h0000_0001);
    apb(1'b1, mrs_pkg::OFF_COMP_SEL, 32'h0000_0001);
    apb(1'b1, mrs_pkg::OFF_INTERVAL, 32'h0000_0000);
    dump();
    u_mrs_front_end.send(5'h00, 32'h0000_0064, 32'h0000_0000);
    u_mrs_front_end.send(5'h00, 32'h0000_00C8, 32'h0000_0000);
    u_mrs_front_end.send(5'h01, 32'h0000_03E7, 32'h0000_000A);
    u_mrs_front_end.send(5'h01, 32'h0000_03E7, 32'h0000_0014);
    dump();
    chk(recs[0], 32'h4396_0000);
    chk(recs[1], 32'h4170_0000);
    apb(1'b1, mrs_pkg::OFF_CTRL, 32'h0000_0003);
    apb(1'b1, mrs_pkg::OFF_SCALE, 32'h0000_8000);
    u_mrs_front_end.send(5'h00, 32'h0000_012C, 32'h0000_0000);
    u_mrs_front_end.send(5'h01, 32'h0000_0000, 32'hFFFF_FFFF);
    u_mrs_front_end.send(5'h11, 32'h0000_0000, 32'h0000_0200);
    dump();
    chk(recs[0], 32'h0000_0096);
    chk(recs[1], 32'h0000_3FFF);
    chk(recs[17], 32'h0000_0100);
    $display("load profile done");
  endtask : t_lp
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_store();
    t_hd();
    t_lp();
    close_out();
  end
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule : meter_register_storage_test
`default_nettype wire
